// ==== design/slc_pkg.sv ====
// shared constants for the synthesizer loop configuration registers
package slc_pkg;
    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register byte addresses
    localparam logic [7:0] ADDR_PRESC_LO = 8'h56;
    localparam logic [7:0] ADDR_PRESC_HI = 8'h57;
    localparam logic [7:0] ADDR_CP_CTRL  = 8'h58;
    localparam logic [7:0] ADDR_EN_CTRL  = 8'h59;
    localparam logic [7:0] ADDR_RES_CTRL = 8'h5A;
    localparam logic [7:0] ADDR_CAP_CTRL = 8'h5B;

    // power-on values
    localparam logic [7:0] RST_PRESC_LO = 8'h78;
    localparam logic [7:0] RST_PRESC_HI = 8'h40;
    localparam logic [7:0] RST_CP_CTRL  = 8'h12;
    localparam logic [7:0] RST_EN_CTRL  = 8'h41;
    localparam logic [7:0] RST_RES_CTRL = 8'h2F;
    localparam logic [7:0] RST_CAP_CTRL = 8'h27;

    // writable bits; bit 7 of the last three is unimplemented
    localparam logic [7:0] WMASK_FULL = 8'hFF;
    localparam logic [7:0] WMASK_LOW7 = 8'h7F;

    // field positions
    localparam int PRESC_HI_LSB = 0;
    localparam int PRESC_HI_W   = 4;
    localparam int CP_CODE_LSB  = 0;
    localparam int CP_CODE_W    = 4;
    localparam int EN_SYNTH_BIT = 1;
    localparam int EN_REFDV_BIT = 4;
    localparam int LF_CODE_LSB  = 0;
    localparam int LF_CODE_W    = 5;
    localparam int UNIMPL_BIT   = 7;

    // divider widths and limits
    localparam int FB_RATIO_W  = 12;
    localparam int REF_RATIO_W = 10;
    localparam logic [11:0] FB_RATIO_ONE  = 12'h001;
    localparam logic [9:0]  REF_RATIO_ONE = 10'h001;
    localparam logic [9:0]  REF_RATIO_BAD = 10'h002;

    // analog scale for the bias and loop-filter readouts
    localparam int CP_UA_W      = 9;
    localparam int CP_BASE_UA   = 0;
    localparam int CP_STEP_UA   = 25;
    localparam int LF_VAL_W     = 10;
    localparam int RES_BASE     = 0;
    localparam int RES_STEP     = 1;
    localparam int CAP_BASE     = 0;
    localparam int CAP_STEP     = 1;
endpackage

// ==== design/slc_div.sv ====
// tick divider: one output pulse per ratio input pulses
`timescale 1ns/1ps
module slc_div
    import slc_pkg::*;
#(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    // control
    input  wire logic         en_in,
    input  wire logic [W-1:0] ratio_in,
    // ticks
    input  wire logic         tick_in,
    output logic              tick_out
);
    logic [W-1:0] cnt_q;
    wire          pass_thru = (ratio_in < W'(2));
    wire          last_cnt  = (cnt_q >= ratio_in - W'(1));

    always_ff @(posedge clk_in) begin
        if (srst_in || !en_in) begin
            cnt_q    <= '0;
            tick_out <= 1'b0;
        end else if (pass_thru) begin
            // codes zero and one both divide by one
            cnt_q    <= '0;
            tick_out <= tick_in;
        end else if (tick_in) begin
            cnt_q    <= last_cnt ? '0 : cnt_q + W'(1);
            tick_out <= last_cnt;
        end else begin
            tick_out <= 1'b0;
        end
    end
endmodule

// ==== design/slc_lin_map.sv ====
// linear code-to-value map, registered
`timescale 1ns/1ps
module slc_lin_map
    import slc_pkg::*;
#(
    parameter int CW   = 5,
    parameter int VW   = 10,
    parameter int BASE = 0,
    parameter int STEP = 1
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          srst_in,
    // code in, value out
    input  wire logic [CW-1:0] code_in,
    output logic      [VW-1:0] value_out
);
    wire [VW-1:0] scaled = VW'(code_in) * VW'(STEP) + VW'(BASE);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            value_out <= VW'(BASE);
        end else begin
            value_out <= scaled;
        end
    end
endmodule

// ==== design/slc_top.sv ====
// synthesizer loop configuration registers and divider control
//
// Behaviour
// R1: codes 2..4095 divide oscillator ticks by N
// R2: codes 0 and 1 pass oscillator unchanged
// R3: charge-pump code linear, 25 uA steps, default 0010
// R4: enable bit 4 enables reference divider, else bypass
// R5: enable bit 1 switches synthesizer on
// R6: software keeps factory trim bits unchanged
// R7: bit 7 of 0x59-0x5B reads zero
// R8: resistor code bits 4-0, default 01111
// R9: series capacitor code bits 4-0, default 00111
// R10: resistance grows linearly with code
// R11: software picks loop codes for comparison rate
// R12: software sets divider enable for reference ratio
// R13: fields reset to defaults, hold until written
`timescale 1ns/1ps
module slc_top
    import slc_pkg::*;
(
    // clock and reset
    input  wire logic                   sys_clk_in,
    input  wire logic                   srst_in,
    // register port
    input  wire logic [ADDR_W-1:0]      reg_addr_in,
    input  wire logic [DATA_W-1:0]      reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [DATA_W-1:0]      reg_rdata_out,
    // loop clock ticks
    input  wire logic                   osc_tick_in,
    input  wire logic                   ref_tick_in,
    input  wire logic [REF_RATIO_W-1:0] reference_divide_ratio_in,
    output logic                        fb_tick_out,
    output logic                        pfd_ref_tick_out,
    // control to the analog loop
    output logic                        synth_enable_out,
    output logic                        reference_divider_enable_out,
    output logic      [FB_RATIO_W-1:0]  feedback_divide_ratio_out,
    output logic      [CP_CODE_W-1:0]   charge_pump_current_code_out,
    output logic      [CP_UA_W-1:0]     charge_pump_current_ua_out,
    output logic      [LF_CODE_W-1:0]   loop_filter_resistor_code_out,
    output logic      [LF_CODE_W-1:0]   loop_filter_series_cap_code_out,
    output logic      [LF_VAL_W-1:0]    loop_filter_res_value_out,
    output logic      [LF_VAL_W-1:0]    loop_filter_cap_value_out
);

    ////////////////////////////////////////////////////////////////
    // register storage

    logic [DATA_W-1:0] presc_lo_q;
    logic [DATA_W-1:0] presc_hi_q;
    logic [DATA_W-1:0] charge_pump_control_q;
    logic [DATA_W-1:0] synth_enable_control_one_q;
    logic [DATA_W-1:0] loop_filter_resistor_q;
    logic [DATA_W-1:0] loop_filter_series_cap_q;
    logic [FB_RATIO_W-1:0] fb_ratio_q;

    ////////////////////////////////////////////////////////////////
    // address decode

    wire hit_presc_lo = (reg_addr_in == ADDR_PRESC_LO);
    wire hit_presc_hi = (reg_addr_in == ADDR_PRESC_HI);
    wire hit_cp       = (reg_addr_in == ADDR_CP_CTRL);
    wire hit_en       = (reg_addr_in == ADDR_EN_CTRL);
    wire hit_res      = (reg_addr_in == ADDR_RES_CTRL);
    wire hit_cap      = (reg_addr_in == ADDR_CAP_CTRL);

    wire wr_presc_lo  = reg_wr_in && hit_presc_lo;
    wire wr_presc_hi  = reg_wr_in && hit_presc_hi;
    wire wr_cp        = reg_wr_in && hit_cp;
    wire wr_en        = reg_wr_in && hit_en;
    wire wr_res       = reg_wr_in && hit_res;
    wire wr_cap       = reg_wr_in && hit_cap;

    // unimplemented top bit is masked on the way in
    wire [DATA_W-1:0] wdata_low7 = reg_wdata_in & WMASK_LOW7; // R7
    wire [DATA_W-1:0] wdata_full = reg_wdata_in & WMASK_FULL;

    ////////////////////////////////////////////////////////////////
    // register writes
    // trim bits stay writable; keeping them is left to software

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            presc_lo_q                 <= RST_PRESC_LO; // R13
            presc_hi_q                 <= RST_PRESC_HI;
            charge_pump_control_q      <= RST_CP_CTRL; // R3
            synth_enable_control_one_q <= RST_EN_CTRL;
            loop_filter_resistor_q     <= RST_RES_CTRL; // R8
            loop_filter_series_cap_q   <= RST_CAP_CTRL; // R9
        end else begin
            if (wr_presc_lo) begin
                presc_lo_q <= wdata_full;
            end
            if (wr_presc_hi) begin
                presc_hi_q <= wdata_full;
            end
            if (wr_cp) begin
                charge_pump_control_q <= wdata_full;
            end
            if (wr_en) begin
                synth_enable_control_one_q <= wdata_low7; // R7
            end
            if (wr_res) begin
                loop_filter_resistor_q <= wdata_low7;
            end
            if (wr_cap) begin
                loop_filter_series_cap_q <= wdata_low7;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // read back

    wire any_hit = hit_presc_lo || hit_presc_hi || hit_cp
                || hit_en || hit_res || hit_cap;

    wire [DATA_W-1:0] rd_mux =
          hit_presc_lo ? presc_lo_q
        : hit_presc_hi ? presc_hi_q
        : hit_cp       ? charge_pump_control_q
        : hit_en       ? synth_enable_control_one_q
        : hit_res      ? loop_filter_resistor_q
        : hit_cap      ? loop_filter_series_cap_q
        : '0;

    // data stands one cycle only; unmapped reads return zero
    wire [DATA_W-1:0] rdata_d = (reg_rd_in && any_hit) ? rd_mux : '0;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // field extraction

    wire [PRESC_HI_W-1:0] presc_hi_code =
        presc_hi_q[PRESC_HI_LSB +: PRESC_HI_W];
    wire [FB_RATIO_W-1:0] presc_code = {presc_hi_code, presc_lo_q};

    wire [CP_CODE_W-1:0] cp_code =
        charge_pump_control_q[CP_CODE_LSB +: CP_CODE_W];
    wire [LF_CODE_W-1:0] res_code =
        loop_filter_resistor_q[LF_CODE_LSB +: LF_CODE_W];
    wire [LF_CODE_W-1:0] cap_code =
        loop_filter_series_cap_q[LF_CODE_LSB +: LF_CODE_W];

    wire synth_en  = synth_enable_control_one_q[EN_SYNTH_BIT]; // R5
    wire refdiv_en = synth_enable_control_one_q[EN_REFDV_BIT]; // R4

    ////////////////////////////////////////////////////////////////
    // effective divide ratios

    // zero and one both mean divide by one
    wire [FB_RATIO_W-1:0] fb_ratio_d =
        (presc_code < FB_RATIO_W'(2)) ? FB_RATIO_ONE : presc_code; // R2

    // ratio two is unsupported and behaves as a bypass
    wire ref_bypass = !refdiv_en
                   || (reference_divide_ratio_in == REF_RATIO_BAD); // R4
    wire [REF_RATIO_W-1:0] ref_ratio_eff =
        ref_bypass ? REF_RATIO_ONE : reference_divide_ratio_in;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            fb_ratio_q <= FB_RATIO_ONE;
        end else begin
            fb_ratio_q <= fb_ratio_d; // R1
        end
    end

    ////////////////////////////////////////////////////////////////
    // dividers; both stop while the synthesizer is off

    slc_div #(
        .W (FB_RATIO_W)
    ) u_fb_div (
        .clk_in   (sys_clk_in),
        .srst_in  (srst_in),
        .en_in    (synth_en), // R5
        .ratio_in (presc_code), // R1
        .tick_in  (osc_tick_in),
        .tick_out (fb_tick_out)
    );

    slc_div #(
        .W (REF_RATIO_W)
    ) u_ref_div (
        .clk_in   (sys_clk_in),
        .srst_in  (srst_in),
        .en_in    (synth_en),
        .ratio_in (ref_ratio_eff), // R4
        .tick_in  (ref_tick_in),
        .tick_out (pfd_ref_tick_out)
    );

    ////////////////////////////////////////////////////////////////
    // analog readouts

    slc_lin_map #(
        .CW   (CP_CODE_W),
        .VW   (CP_UA_W),
        .BASE (CP_BASE_UA),
        .STEP (CP_STEP_UA)
    ) u_cp_map (
        .clk_in    (sys_clk_in),
        .srst_in   (srst_in),
        .code_in   (cp_code), // R3
        .value_out (charge_pump_current_ua_out)
    );

    slc_lin_map #(
        .CW   (LF_CODE_W),
        .VW   (LF_VAL_W),
        .BASE (RES_BASE),
        .STEP (RES_STEP)
    ) u_res_map (
        .clk_in    (sys_clk_in),
        .srst_in   (srst_in),
        .code_in   (res_code), // R10
        .value_out (loop_filter_res_value_out)
    );

    slc_lin_map #(
        .CW   (LF_CODE_W),
        .VW   (LF_VAL_W),
        .BASE (CAP_BASE),
        .STEP (CAP_STEP)
    ) u_cap_map (
        .clk_in    (sys_clk_in),
        .srst_in   (srst_in),
        .code_in   (cap_code),
        .value_out (loop_filter_cap_value_out)
    );

    ////////////////////////////////////////////////////////////////
    // control outputs straight from the register bits; the feedback ratio comes through fb_ratio_q

    assign synth_enable_out                = synth_en;
    assign reference_divider_enable_out    = refdiv_en;
    assign feedback_divide_ratio_out       = fb_ratio_q;
    assign charge_pump_current_code_out    = cp_code;
    assign loop_filter_resistor_code_out   = res_code;
    assign loop_filter_series_cap_code_out = cap_code;

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    a_prescale_ratio: assert property ( // R1
        (!$past(srst_in) && $past(presc_code) >= 12'h002)
        |-> (feedback_divide_ratio_out == $past(presc_code)))
        else $error("feedback ratio differs from code");

    a_prescale_pass: assert property ( // R2
        (synth_en && presc_code < 12'h002 && osc_tick_in)
        |=> fb_tick_out)
        else $error("divide by one did not pass tick");

    a_cp_current: assert property ( // R3
        !$past(srst_in) |->
        (charge_pump_current_ua_out == $past(cp_code) * 9'd25))
        else $error("charge pump current not 25 uA per step");

    a_refdiv_bypass: assert property ( // R4
        (synth_en && !refdiv_en && ref_tick_in)
        |=> pfd_ref_tick_out)
        else $error("bypassed reference did not pass tick");

    a_synth_off: assert property ( // R5
        !synth_en |=> (!fb_tick_out && !pfd_ref_tick_out))
        else $error("ticks while synthesizer disabled");

    a_unimpl_zero: assert property ( // R7
        (reg_rd_in && (hit_en || hit_res || hit_cap))
        |=> !reg_rdata_out[7])
        else $error("unimplemented bit read as one");

    a_res_reset: assert property ( // R8
        $past(srst_in) |-> (res_code == 5'h0F))
        else $error("resistor code default wrong");

    a_cap_reset: assert property ( // R9
        $past(srst_in) |-> (cap_code == 5'h07 && cp_code == 4'h2))
        else $error("capacitor or pump default wrong");

    a_res_linear: assert property ( // R10
        (!$past(srst_in) && res_code == $past(res_code))
        |=> (loop_filter_res_value_out == $past(res_code, 2)))
        else $error("resistance not linear in code");

    a_field_hold: assert property ( // R13
        (!reg_wr_in && !$past(srst_in))
        |=> ($stable(loop_filter_resistor_q)
             && $stable(synth_enable_control_one_q)))
        else $error("register changed without write");

    a_read_once: assert property (
        !reg_rd_in |=> (reg_rdata_out == 8'h00))
        else $error("read data stands beyond one cycle");

    a_fb_no_tick: assert property ( // R1
        (synth_en && presc_code >= 12'h002 && !osc_tick_in)
        |=> !fb_tick_out)
        else $error("feedback tick without oscillator tick");

    a_ref_no_tick: assert property ( // R4
        (synth_en && ref_ratio_eff > REF_RATIO_ONE && !ref_tick_in)
        |=> !pfd_ref_tick_out)
        else $error("reference tick without input tick");

    a_ref_ratio_two: assert property ( // R4
        (synth_en && reference_divide_ratio_in == REF_RATIO_BAD && ref_tick_in)
        |=> pfd_ref_tick_out)
        else $error("reference ratio two did not pass tick");

    a_unimpl_stored: assert property ( // R7
        !synth_enable_control_one_q[UNIMPL_BIT] && !loop_filter_resistor_q[UNIMPL_BIT]
        && !loop_filter_series_cap_q[UNIMPL_BIT])
        else $error("unimplemented bit stored as one");

    a_cap_linear: assert property ( // R9
        !$past(srst_in)
        |-> (loop_filter_cap_value_out == $past(cap_code) * CAP_STEP + CAP_BASE))
        else $error("capacitor readout not linear in code");

    a_write_lands: assert property ( // R13
        (reg_wr_in && hit_res && !srst_in)
        |=> (loop_filter_resistor_q == ($past(reg_wdata_in) & WMASK_LOW7)))
        else $error("resistor write did not land");

    a_read_value: assert property (
        (reg_rd_in && hit_cp && !srst_in)
        |=> (reg_rdata_out == $past(charge_pump_control_q)))
        else $error("pump control read back wrong");

endmodule

// ==== test/slc_tb.sv ====
// self-checking bench for the synthesizer loop configuration registers
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); end end
module testbench
    import slc_pkg::*;
;
    // clock, reset and counters
    logic                   sys_clk_in;
    logic                   srst_in;
    int                     errors;
    int                     compares;
    int                     fb_cnt;
    int                     ref_cnt;
    // register port
    logic [ADDR_W-1:0]      reg_addr_in;
    logic [DATA_W-1:0]      reg_wdata_in;
    logic                   reg_wr_in;
    logic                   reg_rd_in;
    logic [DATA_W-1:0]      reg_rdata_out;
    // ticks and loop controls
    logic                   osc_tick_in;
    logic                   ref_tick_in;
    logic [REF_RATIO_W-1:0] reference_divide_ratio_in;
    logic                   fb_tick_out;
    logic                   pfd_ref_tick_out;
    logic                   synth_enable_out;
    logic                   reference_divider_enable_out;
    logic [FB_RATIO_W-1:0]  feedback_divide_ratio_out;
    logic [CP_CODE_W-1:0]   charge_pump_current_code_out;
    logic [CP_UA_W-1:0]     charge_pump_current_ua_out;
    logic [LF_CODE_W-1:0]   loop_filter_resistor_code_out;
    logic [LF_CODE_W-1:0]   loop_filter_series_cap_code_out;
    logic [LF_VAL_W-1:0]    loop_filter_res_value_out;
    logic [LF_VAL_W-1:0]    loop_filter_cap_value_out;
    logic [7:0]             addr_tab [6] = '{ADDR_PRESC_LO, ADDR_PRESC_HI, ADDR_CP_CTRL,
                                             ADDR_EN_CTRL, ADDR_RES_CTRL, ADDR_CAP_CTRL};
    logic [7:0]             rst_tab  [6] = '{RST_PRESC_LO, RST_PRESC_HI, RST_CP_CTRL,
                                             RST_EN_CTRL, RST_RES_CTRL, RST_CAP_CTRL};
    logic [7:0]             mask_tab [6] = '{WMASK_FULL, WMASK_FULL, WMASK_FULL,
                                             WMASK_LOW7, WMASK_LOW7, WMASK_LOW7};

    slc_top dut (
        .sys_clk_in                      (sys_clk_in),
        .srst_in                         (srst_in),
        .reg_addr_in                     (reg_addr_in),
        .reg_wdata_in                    (reg_wdata_in),
        .reg_wr_in                       (reg_wr_in),
        .reg_rd_in                       (reg_rd_in),
        .reg_rdata_out                   (reg_rdata_out),
        .osc_tick_in                     (osc_tick_in),
        .ref_tick_in                     (ref_tick_in),
        .reference_divide_ratio_in       (reference_divide_ratio_in),
        .fb_tick_out                     (fb_tick_out),
        .pfd_ref_tick_out                (pfd_ref_tick_out),
        .synth_enable_out                (synth_enable_out),
        .reference_divider_enable_out    (reference_divider_enable_out),
        .feedback_divide_ratio_out       (feedback_divide_ratio_out),
        .charge_pump_current_code_out    (charge_pump_current_code_out),
        .charge_pump_current_ua_out      (charge_pump_current_ua_out),
        .loop_filter_resistor_code_out   (loop_filter_resistor_code_out),
        .loop_filter_series_cap_code_out (loop_filter_series_cap_code_out),
        .loop_filter_res_value_out       (loop_filter_res_value_out),
        .loop_filter_cap_value_out       (loop_filter_cap_value_out)
    );

    always #50 sys_clk_in = ~sys_clk_in;

    // output pulses last one cycle, so one count per high edge
    always @(posedge sys_clk_in) begin
        if (fb_tick_out === 1'b1) fb_cnt++;
        if (pfd_ref_tick_out === 1'b1) ref_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus and tick drivers
    // write strobe stands for exactly one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        reg_rd_in    <= 1'b0;
        @(posedge sys_clk_in);
        reg_wr_in    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wr_in   <= 1'b0;
        reg_rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask

    task automatic ticks(input int n, input logic o, input logic r);
        repeat (n) @(posedge sys_clk_in) begin
            reg_wr_in   <= 1'b0;
            reg_rd_in   <= 1'b0;
            osc_tick_in <= o;
            ref_tick_in <= r;
        end
        @(posedge sys_clk_in);
        osc_tick_in <= 1'b0;
        ref_tick_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic idle(input int n);
        ticks(0, 1'b0, 1'b0);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic do_reset();
        @(posedge sys_clk_in);
        srst_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        srst_in <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_defaults();
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            rd(addr_tab[i], d);
            `CHK(d, rst_tab[i])
        end
        `CHK(synth_enable_out, 1'b0)
        `CHK(reference_divider_enable_out, 1'b0)
        `CHK(charge_pump_current_code_out, 4'h2)
        `CHK(charge_pump_current_ua_out, 9'(2 * CP_STEP_UA + CP_BASE_UA))
        `CHK(loop_filter_resistor_code_out, 5'h0F)
        `CHK(loop_filter_series_cap_code_out, 5'h07)
        `CHK(feedback_divide_ratio_out, 12'h078)
        $display("test defaults done");
    endtask

    task automatic t_access(input logic [7:0] v);
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            wr(addr_tab[i], v);
            rd(addr_tab[i], d);
            `CHK(d, v & mask_tab[i])
        end
        wr(8'h60, 8'hFF);
        rd(8'h60, d);
        `CHK(d, 8'h00)
        idle(2);
        `CHK(charge_pump_current_code_out, v[3:0])
        `CHK(loop_filter_resistor_code_out, v[4:0])
        `CHK(loop_filter_series_cap_code_out, v[4:0])
        `CHK(synth_enable_out, v[1])
        $display("test access %h done", v);
    endtask

    task automatic t_linear();
        for (int c = 0; c < 32; c++) begin
            // trim bits rewritten with their power-on values
            wr(ADDR_RES_CTRL, {3'b001, 5'(c)});
            wr(ADDR_CAP_CTRL, {3'b001, 5'(c)});
            wr(ADDR_CP_CTRL, {4'h1, 4'(c)});
            idle(2);
            `CHK(loop_filter_resistor_code_out, 5'(c))
            `CHK(loop_filter_res_value_out, LF_VAL_W'(c * RES_STEP + RES_BASE))
            `CHK(loop_filter_cap_value_out, LF_VAL_W'(c * CAP_STEP + CAP_BASE))
            `CHK(charge_pump_current_ua_out, CP_UA_W'((c % 16) * CP_STEP_UA + CP_BASE_UA))
        end
        $display("test linear done");
    endtask

    task automatic t_fb(input logic [11:0] code, input int n, input int exp);
        // disabling first clears the divider so the count starts afresh
        wr(ADDR_EN_CTRL, 8'h41);
        wr(ADDR_PRESC_LO, code[7:0]);
        wr(ADDR_PRESC_HI, {4'h4, code[11:8]});
        wr(ADDR_EN_CTRL, 8'h43);
        idle(2);
        `CHK(feedback_divide_ratio_out, (code < 12'h002) ? FB_RATIO_ONE : code)
        fb_cnt = 0;
        ticks(n, 1'b1, 1'b0);
        `CHK(fb_cnt, exp)
        $display("test fb %h done", code);
    endtask

    task automatic t_ref(input logic [7:0] en, input logic [9:0] ratio, input int n, input int exp);
        @(posedge sys_clk_in);
        reference_divide_ratio_in <= ratio;
        wr(ADDR_EN_CTRL, 8'h41);
        wr(ADDR_EN_CTRL, en);
        idle(2);
        `CHK(reference_divider_enable_out, en[4])
        `CHK(synth_enable_out, en[1])
        fb_cnt  = 0;
        ref_cnt = 0;
        ticks(n, 1'b1, 1'b1);
        `CHK(ref_cnt, exp)
        if (en[1] == 1'b0) `CHK(fb_cnt, 0)
        $display("test ref %h %h done", en, ratio);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // run control
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        // tests need about 13k cycles; the limit leaves ample margin
        #(40000 * 100);
        errors++;
        conclude();
    end

    initial begin
        sys_clk_in = 1'b0;
        srst_in = 1'b1;
        errors = 0;
        compares = 0;
        fb_cnt = 0;
        ref_cnt = 0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        osc_tick_in = 1'b0;
        ref_tick_in = 1'b0;
        reference_divide_ratio_in = 10'h000;
        do_reset();
        t_defaults();
        t_access(8'hFF);
        t_access(8'h00);
        // reset in mid-run must bring every field back
        do_reset();
        t_defaults();
        t_linear();
        t_fb(12'h000, 5, 5);
        t_fb(12'h001, 5, 5);
        t_fb(12'h002, 6, 3);
        t_fb(12'h003, 7, 2);
        t_fb(12'hFFE, 4094, 1);
        t_fb(12'hFFF, 4094, 0);
        t_fb(12'hFFF, 4095, 1);
        t_ref(8'h43, 10'h003, 6, 6);
        t_ref(8'h53, 10'h003, 6, 2);
        t_ref(8'h53, 10'h002, 6, 6);
        t_ref(8'h53, 10'h000, 4, 4);
        t_ref(8'h51, 10'h003, 6, 0);
        conclude();
    end
endmodule
